//--- hdl/slice_ctl.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module slice_ctl
  import slice_ctl_pkg::*;
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [DW-1:0] y, // alu result bus
  output logic carry_out, // carry of last microcycle
  output logic write_n, // slice write output, low enables
  output logic ram_write_n, // ram write strobe seen by the slices
  output logic [11:0] shared_field, // branch, count or i/o bits
  output logic field_sel, // shared field meaning
  output logic micro_status_load_n, // micro status register enable
  output logic shift_unit_enable_n, // shift operation enable
  output logic [3:0] next_addr, // sequencer next-address instruction
  output logic [3:0] test_select, // sequencer test input select
  output logic test_polarity, // test signal polarity
  output logic ir_load_n, // instruction register load enable
  output logic [3:0] multiway_sel // multi-way branch source
);

  microword_t stage_q; // microword staged by software
  microword_t pipe_q; // pipeline word, drives the microcycle
  logic [31:0] ctrl_q;
  logic [DW-1:0] ext_a_q, ext_b_q;
  logic [DW-1:0] q_q;
  logic sc_q; // sign-compare flip-flop
  logic step_q, exec_q;
  logic ovr_q, zero_q, neg_q;
  logic [DW-1:0] ram_q [RAM_WORDS];
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q, w_have_q;

  // add with carry, flags included
  function automatic alu_res_t add_c(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                     input logic c);
    alu_res_t res;
    logic [DW:0] sum;
    sum = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, c};
    res.f = sum[DW-1:0];
    res.cout = sum[DW];
    res.ovr = (a[DW-1] == b[DW-1]) && (sum[DW-1] != a[DW-1]);
    return res;
  endfunction

  // the sixteen ordinary function codes
  function automatic alu_res_t alu_op(input logic [3:0] code, input logic i0,
                                      input logic [DW-1:0] r, input logic [DW-1:0] s,
                                      input logic c);
    alu_res_t res;
    res = '0;
    case (code)
      4'h0: res.f = i0 ? {DW{1'b1}} : s;
      4'h1: res = add_c(s, ~r, c);
      4'h2: res = add_c(r, ~s, c);
      4'h3: res = add_c(r, s, c);
      4'h4: res = add_c(s, '0, c);
      4'h5: res = add_c(~s, '0, c);
      4'h6: res = add_c(r, '0, c);
      4'h7: res = add_c(~r, '0, c);
      4'h8: res.f = '0;
      4'h9: res.f = ~r & s;
      4'hA: res.f = ~(r ^ s);
      4'hB: res.f = r ^ s;
      4'hC: res.f = r & s;
      4'hD: res.f = ~(r | s);
      4'hE: res.f = ~(r & s);
      default: res.f = r | s;
    endcase
    return res;
  endfunction

  // operand routing and decode of the held pipeline word
  logic [DW-1:0] r_op, s_op;
  logic special;
  logic cin;
  always_comb
  begin
    r_op = pipe_q.r_from_ext ? ext_a_q : ram_q[ctrl_q[CTRL_AADDR_LSB +: 4]];
    if (pipe_q.s_from_q)
      s_op = q_q;
    else if (pipe_q.i0)
      s_op = ext_b_q;
    else
      s_op = ram_q[ctrl_q[CTRL_BADDR_LSB +: 4]];
    special = (pipe_q.func == FN_SPECIAL) && !pipe_q.i0 && !pipe_q.write_qualifier_n;
    cin = ctrl_q[CTRL_CIN_BIT];
  end

  // result, q and sign-compare next values for one microcycle
  alu_res_t res;
  alu_res_t tmp;
  logic [DW-1:0] q_d;
  logic sc_d;
  logic q_load;
  always_comb
  begin
    res = alu_op(pipe_q.func, pipe_q.i0, r_op, s_op, cin);
    tmp = '0;
    q_d = q_q;
    sc_d = sc_q;
    q_load = (pipe_q.dest == DST_FQ_A) || (pipe_q.dest == DST_FQ_B);
    if (!q_load)
      q_d = q_q;
    else
      q_d = res.f;
    if (special)
    begin
      q_load = 1'b1;
      case (pipe_q.dest)
        SP_UMUL:
        begin
          tmp = add_c(q_q[0] ? r_op : '0, s_op, cin);
          res = tmp;
          res.f = {tmp.cout, tmp.f[DW-1:1]};
          q_d = {tmp.f[0], q_q[DW-1:1]};
        end
        SP_TMUL, SP_TMUL_LAST:
        begin
          if (pipe_q.dest == SP_TMUL)
            tmp = add_c(q_q[0] ? r_op : '0, s_op, cin);
          else
            tmp = add_c(s_op, q_q[0] ? ~r_op : '0, q_q[0] ? cin : 1'b0);
          res = tmp;
          res.f = {tmp.f[DW-1] ^ tmp.ovr, tmp.f[DW-1:1]};
          q_d = {tmp.f[0], q_q[DW-1:1]};
        end
        SP_INC:
        begin
          res = add_c(s_op, {{(DW-1){1'b0}}, 1'b1}, cin);
          q_load = 1'b0;
        end
        SP_SIGNMAG:
        begin
          tmp = add_c(~s_op, '0, 1'b1);
          res = tmp;
          res.f = s_op[DW-1] ? {s_op[DW-1], tmp.f[DW-2:0]} : s_op;
          q_load = 1'b0;
        end
        SP_SNORM:
        begin
          res = '0;
          res.f = q_q;
          q_d = {q_q[DW-2:0], 1'b0};
        end
        SP_DNORM_DIV1:
        begin
          res = '0;
          res.f = {s_op[DW-2:0], q_q[DW-1]};
          q_d = {q_q[DW-2:0], ~(s_op[DW-1] ^ r_op[DW-1])};
          sc_d = s_op[DW-1] ^ r_op[DW-1];
        end
        SP_DIV:
        begin
          tmp = sc_q ? add_c(s_op, r_op, cin) : add_c(s_op, ~r_op, cin);
          res = tmp;
          res.f = {tmp.f[DW-2:0], q_q[DW-1]};
          q_d = {q_q[DW-2:0], ~(tmp.f[DW-1] ^ r_op[DW-1])};
          sc_d = tmp.f[DW-1] ^ r_op[DW-1];
        end
        default:
        begin
          res = add_c(s_op, '0, cin);
          q_load = 1'b0;
        end
      endcase
    end
  end

  // microcycle sequencing: go bit, capture, execute
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pipe_q <= microword_t'(MW_RESET);
      exec_q <= 1'b0;
    end
    else
    begin
      exec_q <= step_q;
      if (step_q)
        pipe_q <= stage_q;
    end
  end

  // datapath state written at the end of an executed microcycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      y <= '0;
      carry_out <= 1'b0;
      ovr_q <= 1'b0;
      zero_q <= 1'b1;
      neg_q <= 1'b0;
      q_q <= '0;
      sc_q <= 1'b0;
    end
    else if (exec_q)
    begin
      y <= res.f;
      carry_out <= res.cout;
      ovr_q <= res.ovr;
      zero_q <= (res.f == '0);
      neg_q <= res.f[DW-1];
      if (!pipe_q.write_qualifier_n)
      begin
        sc_q <= sc_d;
        if (q_load)
          q_q <= q_d;
      end
    end
  end

  // two-port register file, written at the b address
  always_ff @(posedge aclk)
  begin
    if (exec_q && !pipe_q.write_qualifier_n && !ctrl_q[CTRL_RAMWR_BIT])
      ram_q[ctrl_q[CTRL_BADDR_LSB +: 4]] <= res.f;
  end

  // sequencer and status unit controls straight from the pipeline word; ram write strobe from the control register
  assign write_n = pipe_q.write_qualifier_n;
  assign shared_field = pipe_q.shared_field;
  assign field_sel = pipe_q.field_sel;
  assign micro_status_load_n = pipe_q.micro_status_load_n;
  assign shift_unit_enable_n = pipe_q.shift_unit_enable_n;
  assign next_addr = pipe_q.next_addr;
  assign test_select = pipe_q.test_select;
  assign test_polarity = pipe_q.test_polarity;
  assign ir_load_n = pipe_q.ir_load_n;
  assign multiway_sel = pipe_q.multiway_sel;
  assign ram_write_n = ctrl_q[CTRL_RAMWR_BIT];

  // write channel capture, address and data in either order
  logic do_write;
  assign do_write = aw_have_q && w_have_q && !bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        if ((aw_addr_q == MW_LO_OFF) || (aw_addr_q == MW_HI_OFF)
            || (aw_addr_q == CTRL_OFF) || (aw_addr_q == EXT_OFF))
          bresp <= RESP_OKAY;
        else
          bresp <= RESP_DECERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // writable registers with byte strobes; go bit self-clears as a step pulse
  logic [MW_BITS-1:0] stage_bits;
  assign stage_bits = stage_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage_q <= microword_t'(MW_RESET);
      ctrl_q <= CTRL_RESET;
      ext_a_q <= '0;
      ext_b_q <= '0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= 1'b0;
      ctrl_q[CTRL_GO_BIT] <= 1'b0;
      if (do_write)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (w_strb_q[i])
          begin
            if (aw_addr_q == MW_LO_OFF)
              stage_q[8*i +: 8] <= w_data_q[8*i +: 8];
            else if (aw_addr_q == MW_HI_OFF && i < 2)
            begin
              if (i == 0)
                stage_q[39:32] <= w_data_q[7:0];
              else
                stage_q[40] <= w_data_q[8];
            end
            else if (aw_addr_q == CTRL_OFF)
              ctrl_q[8*i +: 8] <= w_data_q[8*i +: 8];
            else if (aw_addr_q == EXT_OFF && i < 2)
              ext_a_q[8*i +: 8] <= w_data_q[8*i +: 8];
            else if (aw_addr_q == EXT_OFF)
              ext_b_q[8*(i%2) +: 8] <= w_data_q[8*i +: 8];
          end
        end
        if (aw_addr_q == CTRL_OFF && w_strb_q[0] && w_data_q[CTRL_GO_BIT])
          step_q <= 1'b1;
      end
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr == MW_LO_OFF)
        rdata <= stage_bits[31:0];
      else if (araddr == MW_HI_OFF)
        rdata <= {23'h00_0000, stage_bits[MW_BITS-1:32]};
      else if (araddr == CTRL_OFF)
        rdata <= ctrl_q;
      else if (araddr == EXT_OFF)
        rdata <= {ext_b_q, ext_a_q};
      else if (araddr == RESULT_OFF)
        rdata <= {11'h000, sc_q, ovr_q, neg_q, zero_q, carry_out, y};
      else if (araddr == QREG_OFF)
        rdata <= {16'h0000, q_q};
      else
      begin
        rdata <= '0;
        rresp <= RESP_DECERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks on the microcycle datapath
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  q_write_block_a: assert property (exec_q && pipe_q.write_qualifier_n |=> $stable(q_q))
    else $error("q changed with write qualifier high");
  add_result_a: assert property (exec_q && !special && pipe_q.func == 4'h3
    |=> y == DW'($past(r_op) + $past(s_op) + DW'($past(cin))))
    else $error("r plus s result wrong");
  and_result_a: assert property (exec_q && pipe_q.func == 4'hC
    |=> y == ($past(r_op) & $past(s_op)))
    else $error("and result wrong");
  pass_s_a: assert property (exec_q && pipe_q.func == 4'h4
    |=> y == DW'($past(s_op) + DW'($past(cin))))
    else $error("pass s result wrong");
  ext_route_a: assert property (exec_q && pipe_q.func == 4'h6 && pipe_q.r_from_ext
    |=> y == DW'($past(ext_a_q) + DW'($past(cin))))
    else $error("r not taken from bus a");
  all_ones_a: assert property (exec_q && pipe_q.func == FN_SPECIAL && pipe_q.i0
    |=> y == {DW{1'b1}})
    else $error("code 0 with i0 high not all ones");
  inc_special_a: assert property (exec_q && special && pipe_q.dest == SP_INC
    |=> y == DW'($past(s_op) + 1 + DW'($past(cin))))
    else $error("increment special wrong");
  pipe_hold_a: assert property (!step_q |=> $stable(pipe_q))
    else $error("pipeline word moved without a step");
  pipe_load_a: assert property (step_q |=> write_n == $past(stage_q.write_qualifier_n))
    else $error("write output not from captured word");
  umul_shift_a: assert property (exec_q && special && pipe_q.dest == SP_UMUL
    |=> q_q[DW-2:0] == $past(q_q[DW-1:1]))
    else $error("multiply did not shift q");

  special_run_c: cover property (step_q ##1 exec_q && special ##1 step_q ##1 exec_q && special);
  div_step_c: cover property (exec_q && special && pipe_q.dest == SP_DIV);
  ram_write_c: cover property (exec_q && !pipe_q.write_qualifier_n && !ram_write_n);

endmodule

//--- hdl/slice_ctl_pkg.sv
package slice_ctl_pkg;

  // register byte addresses
  localparam logic [7:0] MW_LO_OFF = 8'h00;
  localparam logic [7:0] MW_HI_OFF = 8'h04;
  localparam logic [7:0] CTRL_OFF = 8'h08;
  localparam logic [7:0] EXT_OFF = 8'h0C;
  localparam logic [7:0] RESULT_OFF = 8'h10;
  localparam logic [7:0] QREG_OFF = 8'h14;

  // control register field positions
  localparam int CTRL_CIN_BIT = 0;
  localparam int CTRL_RAMWR_BIT = 1;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_AADDR_LSB = 4;
  localparam int CTRL_BADDR_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // width of one microword and of the slice cascade
  localparam int MW_BITS = 41;
  localparam int DW = 16;
  localparam int RAM_WORDS = 16;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // function codes
  localparam logic [3:0] FN_SPECIAL = 4'h0;

  // special destination codes
  localparam logic [3:0] SP_UMUL = 4'h0;
  localparam logic [3:0] SP_TMUL = 4'h2;
  localparam logic [3:0] SP_INC = 4'h4;
  localparam logic [3:0] SP_SIGNMAG = 4'h5;
  localparam logic [3:0] SP_TMUL_LAST = 4'h6;
  localparam logic [3:0] SP_SNORM = 4'h8;
  localparam logic [3:0] SP_DNORM_DIV1 = 4'hA;
  localparam logic [3:0] SP_DIV = 4'hC;

  // destination codes that load q from f in normal mode
  localparam logic [3:0] DST_FQ_A = 4'h6;
  localparam logic [3:0] DST_FQ_B = 4'h7;

  // pipeline word, most significant bit (pipeline_word_bit 40) first
  typedef struct packed {
    logic [3:0] dest;
    logic [3:0] func;
    logic i0;
    logic s_from_q;
    logic r_from_ext;
    logic [3:0] multiway_sel;
    logic ir_load_n;
    logic test_polarity;
    logic [3:0] test_select;
    logic [3:0] next_addr;
    logic shift_unit_enable_n;
    logic micro_status_load_n;
    logic write_qualifier_n;
    logic field_sel;
    logic [11:0] shared_field;
  } microword_t;

  localparam logic [MW_BITS-1:0] MW_RESET = 41'h00_0000_E000;

  // alu flags carried with a result
  typedef struct packed {
    logic ovr;
    logic cout;
    logic [DW-1:0] f;
  } alu_res_t;

endpackage

//--- bench/seq_model.sv
`timescale 1ns/1ps
// sequencer side: decodes the control fields handed over each microcycle
module seq_model #(
  parameter logic [15:0] TEST_INPUTS = 16'h5A3C // arbitrary test input pattern
) (
  input wire logic [11:0] shared_field, // branch, count or i/o bits
  input wire logic field_sel, // shared field meaning
  input wire logic micro_status_load_n, // status register enable
  input wire logic shift_unit_enable_n, // shift enable
  input wire logic [3:0] next_addr, // next-address instruction
  input wire logic [3:0] test_select, // test input select
  input wire logic test_polarity, // test polarity
  input wire logic ir_load_n, // instruction register load
  input wire logic [3:0] multiway_sel, // multi-way branch source
  output logic [11:0] branch_addr, // branch or count value
  output logic [11:0] io_ctrl, // i/o control bits
  output logic [3:0] next_instr, // instruction obeyed
  output logic [3:0] branch_src, // multi-way source used
  output logic cond, // test seen by the sequencer
  output logic status_en, // status register enabled
  output logic shift_en, // shift enabled
  output logic ir_en // instruction register loads
);
  // shared field split by its selector
  assign branch_addr = field_sel ? 12'h000 : shared_field;
  assign io_ctrl = field_sel ? shared_field : 12'h000;
  // sequencer instruction and test path
  assign next_instr = next_addr;
  assign cond = TEST_INPUTS[test_select] ^ test_polarity;
  assign branch_src = multiway_sel;
  // active-low enables
  assign status_en = !micro_status_load_n;
  assign shift_en = !shift_unit_enable_n;
  assign ir_en = !ir_load_n;
endmodule

//--- bench/microcoded_alu_slice_control_tb.sv
`timescale 1ns/1ps
module microcoded_alu_slice_control_tb
  import slice_ctl_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, carry_out, write_n, ram_write_n;
  logic field_sel, micro_status_load_n, shift_unit_enable_n, test_polarity, ir_load_n;
  logic cond, status_en, shift_en, ir_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [DW-1:0] y;
  logic [11:0] shared_field, branch_addr, io_ctrl;
  logic [3:0] next_addr, test_select, multiway_sel, next_instr, branch_src;
  int err_total = 0;
  int total_checks = 0;
  localparam logic [15:0] TESTS = 16'h5A3C;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  slice_ctl i_slice_ctl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .y(y), .carry_out(carry_out), .write_n(write_n), .ram_write_n(ram_write_n),
    .shared_field(shared_field), .field_sel(field_sel),
    .micro_status_load_n(micro_status_load_n), .shift_unit_enable_n(shift_unit_enable_n),
    .next_addr(next_addr), .test_select(test_select), .test_polarity(test_polarity),
    .ir_load_n(ir_load_n), .multiway_sel(multiway_sel));

  seq_model #(.TEST_INPUTS(TESTS)) i_seq_model (.shared_field(shared_field),
    .field_sel(field_sel), .micro_status_load_n(micro_status_load_n),
    .shift_unit_enable_n(shift_unit_enable_n), .next_addr(next_addr),
    .test_select(test_select), .test_polarity(test_polarity), .ir_load_n(ir_load_n),
    .multiway_sel(multiway_sel), .branch_addr(branch_addr), .io_ctrl(io_ctrl),
    .next_instr(next_instr), .branch_src(branch_src), .cond(cond), .status_en(status_en),
    .shift_en(shift_en), .ir_en(ir_en));

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a wait that ran out
  task automatic timeout();
    err_total++;
    $display("ERROR %0t: bus wait ran out", $time);
    end_of_test();
  endtask

  // bus write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'b01;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  // bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    d = 32'h0000_0000;
    r = 2'b01;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask

  // microword with sequencer fields at their idle values
  function automatic microword_t mw(input logic [3:0] f, input logic [3:0] dst,
    input logic i0, input logic sq, input logic rx, input logic wq);
    mw = microword_t'(MW_RESET);
    mw.func = f;
    mw.dest = dst;
    mw.i0 = i0;
    mw.s_from_q = sq;
    mw.r_from_ext = rx;
    mw.write_qualifier_n = wq;
  endfunction

  // control word with go set
  function automatic logic [31:0] ctl(input logic cin, input logic wn, input logic [3:0] a,
    input logic [3:0] b);
    ctl = 32'h0000_0000;
    ctl[CTRL_CIN_BIT] = cin;
    ctl[CTRL_RAMWR_BIT] = wn;
    ctl[CTRL_GO_BIT] = 1'b1;
    ctl[CTRL_AADDR_LSB +: 4] = a;
    ctl[CTRL_BADDR_LSB +: 4] = b;
  endfunction

  // expected alu output for one function code
  function automatic logic [15:0] alu(input logic [3:0] f, input logic [15:0] r,
    input logic [15:0] s, input logic c);
    case (f)
      4'h0: alu = 16'hFFFF;
      4'h1: alu = s + ~r + c;
      4'h2: alu = r + ~s + c;
      4'h3: alu = r + s + c;
      4'h4: alu = s + c;
      4'h5: alu = ~s + c;
      4'h6: alu = r + c;
      4'h7: alu = ~r + c;
      4'h8: alu = 16'h0000;
      4'h9: alu = ~r & s;
      4'hA: alu = ~(r ^ s);
      4'hB: alu = r ^ s;
      4'hC: alu = r & s;
      4'hD: alu = ~(r | s);
      4'hE: alu = ~(r & s);
      default: alu = r | s;
    endcase
  endfunction

  // stage a microword, run it and read the result word
  task automatic run_mc(input microword_t m, input logic [15:0] ea, input logic [15:0] eb,
    input logic [31:0] c, output logic [31:0] res);
    logic [1:0] r;
    axi_wr(MW_LO_OFF, m[31:0], r);
    axi_wr(MW_HI_OFF, {23'h00_0000, m[40:32]}, r);
    axi_wr(EXT_OFF, {eb, ea}, r);
    axi_wr(CTRL_OFF, c, r);
    repeat (3) @(posedge aclk);
    axi_rd(RESULT_OFF, res, r);
  endtask

  // reset state, readback and refused accesses
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk(write_n, 1'b1);
    chk({micro_status_load_n, shift_unit_enable_n, ram_write_n}, 3'b111);
    chk(y, 16'h0000);
    axi_rd(CTRL_OFF, d, r);
    chk(d, CTRL_RESET);
    axi_wr(MW_LO_OFF, 32'hDEAD_BEEF, r);
    axi_rd(MW_LO_OFF, d, r);
    chk(d, 32'hDEAD_BEEF);
    axi_rd(8'h20, d, r);
    chk(d, 32'h0000_0000);
    chk(r, RESP_DECERR);
    axi_wr(RESULT_OFF, 32'h0000_FFFF, r);
    chk(r, RESP_DECERR);
  endtask

  // every function code with both carry values, operands from the buses
  task automatic test_alu();
    logic [31:0] res;
    for (int k = 0; k < 32; k++)
    begin
      run_mc(mw(k[3:0], 4'h4, 1'b1, 1'b0, 1'b1, 1'b1), 16'h3C5A, 16'h0F96,
        ctl(k[4], 1'b1, 4'h0, 4'h0), res);
      chk(res[15:0], alu(k[3:0], 16'h3C5A, 16'h0F96, k[4]));
    end
  endtask

  // ram written only with strobe and qualifier both low
  task automatic test_ram();
    logic [31:0] res;
    logic [1:0] r;
    run_mc(mw(4'h6, 4'h4, 1'b1, 1'b0, 1'b1, 1'b0), 16'h1234, 16'h0000,
      ctl(1'b0, 1'b0, 4'h0, 4'h3), res);
    chk(ram_write_n, 1'b0);
    run_mc(mw(4'h6, 4'h4, 1'b1, 1'b0, 1'b1, 1'b0), 16'h5555, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h3), res);
    run_mc(mw(4'h6, 4'h4, 1'b1, 1'b0, 1'b1, 1'b1), 16'h7777, 16'h0000,
      ctl(1'b0, 1'b0, 4'h0, 4'h3), res);
    run_mc(mw(4'h6, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1), 16'h0000, 16'h0000,
      ctl(1'b0, 1'b1, 4'h3, 4'h0), res);
    chk(res[15:0], 16'h1234);
    run_mc(mw(4'h4, 4'h4, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0000, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h3), res);
    chk(res[15:0], 16'h1234);
    axi_rd(CTRL_OFF, res, r);
    chk(res, ctl(1'b0, 1'b1, 4'h0, 4'h3) & 32'hFFFF_FFFB);
  endtask

  // q follows the write qualifier, then feeds the s operand
  task automatic test_wq();
    logic [31:0] res;
    logic [1:0] r;
    run_mc(mw(4'h6, DST_FQ_A, 1'b1, 1'b0, 1'b1, 1'b0), 16'h8005, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(write_n, 1'b0);
    axi_rd(QREG_OFF, res, r);
    chk(res[15:0], 16'h8005);
    run_mc(mw(4'h6, DST_FQ_B, 1'b1, 1'b0, 1'b1, 1'b1), 16'h1111, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(write_n, 1'b1);
    axi_rd(QREG_OFF, res, r);
    chk(res[15:0], 16'h8005);
    run_mc(mw(4'h4, 4'h4, 1'b0, 1'b1, 1'b0, 1'b1), 16'h0000, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(res[15:0], 16'h8005);
  endtask

  // sign conversion and increment with s taken from q
  task automatic test_special();
    logic [31:0] res;
    run_mc(mw(FN_SPECIAL, SP_SIGNMAG, 1'b0, 1'b1, 1'b0, 1'b0), 16'h0000, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(res[15:0], 16'hFFFB);
    run_mc(mw(4'h6, DST_FQ_A, 1'b1, 1'b0, 1'b1, 1'b0), 16'h1234, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    run_mc(mw(FN_SPECIAL, SP_INC, 1'b0, 1'b1, 1'b0, 1'b0), 16'h0000, 16'h0000,
      ctl(1'b1, 1'b1, 4'h0, 4'h0), res);
    chk(res[15:0], 16'h1236);
    run_mc(mw(FN_SPECIAL, SP_INC, 1'b0, 1'b1, 1'b0, 1'b0), 16'h0000, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(res[15:0], 16'h1235);
  endtask

  // one unsigned multiply step and one divide step, s from ram b holding 1234
  task automatic test_muldiv();
    logic [31:0] res;
    logic [1:0] r;
    run_mc(mw(4'h6, DST_FQ_A, 1'b1, 1'b0, 1'b1, 1'b0), 16'h0003, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h3), res);
    run_mc(mw(FN_SPECIAL, SP_UMUL, 1'b0, 1'b0, 1'b1, 1'b0), 16'h0010, 16'h0000,
      ctl(1'b0, 1'b1, 4'h0, 4'h3), res);
    chk(res[15:0], 16'h0922);
    axi_rd(QREG_OFF, res, r);
    chk(res[15:0], 16'h0001);
    run_mc(mw(FN_SPECIAL, SP_DIV, 1'b0, 1'b0, 1'b1, 1'b0), 16'h0034, 16'h0000,
      ctl(1'b1, 1'b1, 4'h0, 4'h3), res);
    chk(res[15:0], 16'h2400);
    chk(carry_out, 1'b1);
    axi_rd(QREG_OFF, res, r);
    chk(res[15:0], 16'h0003);
  endtask

  // sequencer fields reach the model and hold until the next go
  task automatic test_seq();
    microword_t m;
    logic [31:0] res;
    logic [1:0] r;
    m = mw(4'hF, 4'h4, 1'b1, 1'b0, 1'b1, 1'b1);
    m.shared_field = 12'hA5C;
    m.next_addr = 4'h9;
    m.test_select = 4'h3;
    m.test_polarity = 1'b1;
    m.ir_load_n = 1'b0;
    m.multiway_sel = 4'h6;
    m.micro_status_load_n = 1'b0;
    run_mc(m, 16'h0000, 16'h0000, ctl(1'b0, 1'b1, 4'h0, 4'h0), res);
    chk(branch_addr, 12'hA5C);
    chk({next_instr, branch_src}, 8'h96);
    chk(cond, TESTS[3] ^ 1'b1);
    chk({status_en, shift_en, ir_en}, 3'b101);
    axi_wr(MW_LO_OFF, 32'h0000_F321, r);
    repeat (2) @(posedge aclk);
    chk(branch_addr, 12'hA5C);
    axi_wr(CTRL_OFF, ctl(1'b0, 1'b1, 4'h0, 4'h0), r);
    repeat (3) @(posedge aclk);
    chk({io_ctrl, branch_addr}, 24'h321_000);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_alu();
    test_ram();
    test_wq();
    test_special();
    test_muldiv();
    test_seq();
    end_of_test();
  end
endmodule
